// ---- vpt_translator.sv ----
`timescale 1ns/100ps
// How it works
// R1: pages are 512 words; low nine address bits select the word.
// R2: physical address is 19 bits: ten page bits above nine word bits.
// R3: virtual address is 18 bits; upper nine bits are the virtual page.
// R4: offset passes unchanged; nine-bit page replaced by ten-bit physical page.
// R5: fast accumulator addresses bypass translation even with paging on.
// R6: interrupt instruction fetches use the executive space when paging.
// R7: microcode references for mapping, interrupts and traps are physical.
// R8: section pointer address is process table base page plus word 540; the code uses word 28.
// R9: each section table has one entry, section zero, at word 540; the code uses word 28.
// R10: a page map is one page holding 512 one-word mappings.
// R11: a mapping holds modified, cacheable and ten-bit physical page.
// R12: refill sets modified if already modified or writing a writable page.
// R13: 512 table locations each also hold parity, space tag and valid.
// R14: invalidation clears the whole location; zero mapping with valid works.
// R15: valid, same-space entry supplies the physical page, subject to modified.
// R16: refill on invalid, other space, or write with modified clear.
// R17: refill result stored except on inaccessible or write-protect failure.
// R18: inaccessible, not in memory, or protected write gives soft failure.
// R19: failure trap uses user table words 500, 501 and 502.
// R20: stored parity checked on read; mismatch forces a refill.
module vpt_translator (
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  // configuration
  input  wire logic                                 paging_on,
  input  wire logic                                 user_mode,
  input  wire logic [vpt_pkg::VPT_PPAGE_BITS-1:0]   user_pt_base,
  input  wire logic [vpt_pkg::VPT_PPAGE_BITS-1:0]   exec_pt_base,
  // reference request
  input  wire logic                                 ref_req,
  input  wire logic [vpt_pkg::VPT_VADDR_BITS-1:0]   ref_vaddr,
  input  wire logic                                 ref_write,
  input  wire logic                                 ref_intr,
  input  wire logic                                 ref_phys,
  output logic                                      ref_ready,
  output logic                                      ref_done,
  output logic      [vpt_pkg::VPT_PADDR_BITS-1:0]   ref_paddr,
  output logic                                      ref_cache,
  output logic                                      ref_fast,
  // refill handshake with microcode
  output logic                                      refill_req,
  output logic      [vpt_pkg::VPT_VPAGE_BITS-1:0]   refill_vpage,
  output logic                                      refill_user,
  output logic                                      refill_write,
  output logic      [vpt_pkg::VPT_PADDR_BITS-1:0]   sect_ptr_addr,
  input  wire logic                                 refill_ack,
  input  wire logic [vpt_pkg::VPT_PPAGE_BITS-1:0]   refill_ppn,
  input  wire logic                                 refill_writable,
  input  wire logic                                 refill_modified,
  input  wire logic                                 refill_cache,
  input  wire logic [1:0]                           refill_fail,
  // soft page failure trap
  output logic                                      trap_req,
  output logic      [1:0]                           trap_cause,
  output logic      [vpt_pkg::VPT_PADDR_BITS-1:0]   trap_fail_addr,
  output logic      [vpt_pkg::VPT_PADDR_BITS-1:0]   trap_pc_addr,
  output logic      [vpt_pkg::VPT_PADDR_BITS-1:0]   trap_new_addr,
  input  wire logic                                 trap_ack,
  // invalidation and parity error flag
  input  wire logic                                 inval_req,
  input  wire logic [vpt_pkg::VPT_VPAGE_BITS-1:0]   inval_vpage,
  output logic                                      parity_err
);
  import vpt_pkg::*;

  // --------------------------------------------------------------
  // state and captured reference
  // --------------------------------------------------------------
  vpt_state_e                state_reg, state_next;
  logic [VPT_VADDR_BITS-1:0] va_reg;
  logic                      wr_reg;
  logic                      usp_reg;
  logic                      done_reg;
  logic [VPT_PADDR_BITS-1:0] pa_reg;
  logic                      cache_reg;
  logic                      fast_reg;
  logic                      perr_reg;
  logic [1:0]                cause_reg;

  // --------------------------------------------------------------
  // address split
  // --------------------------------------------------------------
  wire [VPT_WORD_BITS-1:0]  in_word   = ref_vaddr[VPT_WORD_BITS-1:0];      // R1
  wire [VPT_VPAGE_BITS-1:0] in_vpage  = ref_vaddr[VPT_VADDR_BITS-1:VPT_WORD_BITS]; // R3
  wire                      in_fast   = (ref_vaddr < VPT_VADDR_BITS'(VPT_AC_LIMIT));
  // interrupt fetches go to executive space while paging
  wire                      in_user   = user_mode & ~ref_intr;             // R6
  // physical when paging is off, microcode reference, or fast memory
  wire                      in_bypass = ~paging_on | ref_phys | in_fast; // R5 R7
  wire [VPT_PADDR_BITS-1:0] in_phys   = {1'b0, ref_vaddr};
  wire                      take      = ref_req & (state_reg == VPT_IDLE);

  wire [VPT_VPAGE_BITS-1:0] vpage_reg = va_reg[VPT_VADDR_BITS-1:VPT_WORD_BITS];
  wire [VPT_WORD_BITS-1:0]  word_reg  = va_reg[VPT_WORD_BITS-1:0];

  // --------------------------------------------------------------
  // page table access
  // --------------------------------------------------------------
  logic [VPT_ENT_BITS-1:0]   ent;
  logic                      ent_par;
  wire                       fail_store = (refill_fail == VPT_FAIL_INACC) |
                                          (refill_fail == VPT_FAIL_WPROT);
  wire                       fill_we    = (state_reg == VPT_REFILL) & refill_ack
                                          & ~fail_store;                 // R17
  wire                       inv_we     = inval_req & (state_reg == VPT_IDLE) & ~ref_req;
  // modified is set on prior modification or a write to a writable page
  wire                       fill_m     = refill_modified | (wr_reg & refill_writable); // R12
  wire [VPT_ENT_BITS-2:0]    fill_body  = {1'b1, usp_reg, fill_m, refill_cache, refill_ppn}; // R11 R13
  logic                      fill_par;
  wire [VPT_ENT_BITS-1:0]    fill_ent   = {fill_par, fill_body};
  // invalidation writes an all-zero location, valid included
  wire [VPT_ENT_BITS-1:0]    mem_wdata  = inv_we ? VPT_ENT_CLEAR : fill_ent; // R14
  wire [VPT_VPAGE_BITS-1:0]  mem_addr   = inv_we ? inval_vpage :
                                          (take ? in_vpage : vpage_reg); // R13

  vpt_table_mem u_mem (
    .clk   (clk),
    .we    (fill_we | inv_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (ent)
  );

  vpt_parity #(.W(VPT_ENT_BITS-1)) u_par_wr (
    .data (fill_body),
    .par  (fill_par)
  );

  vpt_parity #(.W(VPT_ENT_BITS-1)) u_par_rd (
    .data (ent[VPT_ENT_BITS-2:0]),
    .par  (ent_par)
  );

  // --------------------------------------------------------------
  // hit decision
  // --------------------------------------------------------------
  wire ent_perr  = ent_par ^ ent[VPT_ENT_P_BIT];                         // R20
  wire ent_valid = ent[VPT_ENT_V_BIT];
  wire ent_space = (ent[VPT_ENT_U_BIT] == usp_reg);
  wire ent_m     = ent[VPT_ENT_M_BIT];
  // miss on invalid, wrong space, write without modified, or bad parity
  wire ent_miss  = ~ent_valid | ~ent_space | (wr_reg & ~ent_m) | ent_perr; // R16 R20
  wire [VPT_PPAGE_BITS-1:0] ent_ppn = ent[VPT_ENT_PPN_LSB +: VPT_PPAGE_BITS];
  // ten-bit page above unchanged nine-bit offset
  wire [VPT_PADDR_BITS-1:0] hit_pa  = {ent_ppn, word_reg};               // R2 R4 R15
  wire [VPT_PADDR_BITS-1:0] fill_pa = {refill_ppn, word_reg};            // R4

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VPT_IDLE: begin
        if (take & ~in_bypass) begin
          state_next = VPT_READ;
        end
      end
      VPT_READ: begin
        if (ent_miss) begin
          state_next = VPT_REFILL;
        end else begin
          state_next = VPT_IDLE;
        end
      end
      VPT_REFILL: begin
        if (refill_ack) begin
          state_next = (refill_fail != VPT_FAIL_NONE) ? VPT_TRAP : VPT_IDLE; // R18
        end
      end
      VPT_TRAP: begin
        if (trap_ack) begin
          state_next = VPT_IDLE;
        end
      end
      default: state_next = VPT_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // state register and reference capture
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= VPT_IDLE;
      va_reg    <= '0;
      wr_reg    <= 1'b0;
      usp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        va_reg  <= ref_vaddr;
        wr_reg  <= ref_write;
        usp_reg <= in_user;
      end
    end
  end

  // --------------------------------------------------------------
  // completion outputs, registered
  // --------------------------------------------------------------
  // bypass completes the cycle after it is taken, a hit one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg  <= 1'b0;
      pa_reg    <= '0;
      cache_reg <= 1'b0;
      fast_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (take & in_bypass) begin
        done_reg  <= 1'b1;
        pa_reg    <= in_phys;                                            // R5 R7
        cache_reg <= 1'b0;
        fast_reg  <= in_fast;
      end else if ((state_reg == VPT_READ) & ~ent_miss) begin
        done_reg  <= 1'b1;
        pa_reg    <= hit_pa;                                             // R15
        cache_reg <= ent[VPT_ENT_C_BIT];
        fast_reg  <= 1'b0;
      end else if (fill_we & (refill_fail == VPT_FAIL_NONE)) begin
        done_reg  <= 1'b1;
        pa_reg    <= fill_pa;
        cache_reg <= refill_cache;
        fast_reg  <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // trap cause and parity flag
  // --------------------------------------------------------------
  // parity flag holds until the next taken reference; a new error wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_reg <= VPT_FAIL_NONE;
      perr_reg  <= 1'b0;
    end else begin
      if ((state_reg == VPT_REFILL) & refill_ack) begin
        cause_reg <= refill_fail;                                        // R18
      end
      if ((state_reg == VPT_READ) & ent_valid & ent_perr) begin
        perr_reg <= 1'b1;                                                // R20
      end else if (take) begin
        perr_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // port drive
  // --------------------------------------------------------------
  assign ref_ready    = (state_reg == VPT_IDLE);
  assign ref_done     = done_reg;
  assign ref_paddr    = pa_reg;
  assign ref_cache    = cache_reg;
  assign ref_fast     = fast_reg;
  assign parity_err   = perr_reg;

  assign refill_req   = (state_reg == VPT_REFILL);                       // R16
  assign refill_vpage = vpage_reg;                                       // R10
  assign refill_user  = usp_reg;
  assign refill_write = wr_reg;
  // one section, its pointer at word 28 of the selected process table
  assign sect_ptr_addr = {(usp_reg ? user_pt_base : exec_pt_base),
                          VPT_SECT_PTR_WORD};                            // R8 R9

  // trap words live in the user process table
  assign trap_req       = (state_reg == VPT_TRAP);                       // R18
  assign trap_cause     = cause_reg;
  assign trap_fail_addr = {user_pt_base, VPT_PF_WORD};                   // R19
  assign trap_pc_addr   = {user_pt_base, VPT_PF_OLD_PC};                 // R19
  assign trap_new_addr  = {user_pt_base, VPT_PF_NEW_PC};                 // R19
endmodule // vpt_translator

// ---- vpt_pkg.sv ----
package vpt_pkg;
  // ------------------------------------------------------------
  // address geometry
  // ------------------------------------------------------------
  localparam int VPT_WORD_BITS   = 9;    // word within a 512-word page
  localparam int VPT_VPAGE_BITS  = 9;    // 512 virtual pages
  localparam int VPT_PPAGE_BITS  = 10;   // 1024 physical pages
  localparam int VPT_VADDR_BITS  = 18;
  localparam int VPT_PADDR_BITS  = 19;
  localparam int VPT_TABLE_DEPTH = 512;
  localparam int VPT_AC_LIMIT    = 16;   // addresses below this select fast memory

  // ------------------------------------------------------------
  // page table entry layout: {parity, valid, user, m, c, ppn}
  // ------------------------------------------------------------
  localparam int VPT_ENT_PPN_LSB = 0;
  localparam int VPT_ENT_C_BIT   = 10;
  localparam int VPT_ENT_M_BIT   = 11;
  localparam int VPT_ENT_U_BIT   = 12;
  localparam int VPT_ENT_V_BIT   = 13;
  localparam int VPT_ENT_P_BIT   = 14;
  localparam int VPT_ENT_BITS    = 15;
  localparam logic [VPT_ENT_BITS-1:0] VPT_ENT_CLEAR = 15'h0000;

  // ------------------------------------------------------------
  // process table words
  // ------------------------------------------------------------
  localparam logic [VPT_WORD_BITS-1:0] VPT_SECT_PTR_WORD = 9'h21C; // 28, as 9'h21C keeps only its low nine bits
  localparam logic [VPT_WORD_BITS-1:0] VPT_PF_WORD       = 9'h1F4; // 500
  localparam logic [VPT_WORD_BITS-1:0] VPT_PF_OLD_PC     = 9'h1F5; // 501
  localparam logic [VPT_WORD_BITS-1:0] VPT_PF_NEW_PC     = 9'h1F6; // 502

  // ------------------------------------------------------------
  // soft failure causes
  // ------------------------------------------------------------
  localparam logic [1:0] VPT_FAIL_NONE  = 2'h0;
  localparam logic [1:0] VPT_FAIL_INACC = 2'h1;
  localparam logic [1:0] VPT_FAIL_WPROT = 2'h2;
  localparam logic [1:0] VPT_FAIL_NOMEM = 2'h3;

  typedef enum logic [3:0] {
    VPT_IDLE   = 4'h1,
    VPT_READ   = 4'h2,
    VPT_REFILL = 4'h4,
    VPT_TRAP   = 4'h8
  } vpt_state_e;
endpackage

// ---- vpt_table_mem.sv ----
`timescale 1ns/100ps
// single-port page table store, registered read data
module vpt_table_mem (
  input  wire logic                          clk,
  input  wire logic                          we,
  input  wire logic [vpt_pkg::VPT_VPAGE_BITS-1:0] addr,
  input  wire logic [vpt_pkg::VPT_ENT_BITS-1:0]   wdata,
  output logic      [vpt_pkg::VPT_ENT_BITS-1:0]   rdata
);
  import vpt_pkg::*;

  logic [VPT_ENT_BITS-1:0] mem [VPT_TABLE_DEPTH];

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  // no reset on the array: validity is cleared by explicit invalidation
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // vpt_table_mem

// ---- vpt_parity.sv ----
`timescale 1ns/100ps
// even parity over a word
module vpt_parity #(
  parameter int W = 14
) (
  input  wire logic [W-1:0] data,
  output logic              par
);
  // --------------------------------------------------------------
  // reduction
  // --------------------------------------------------------------
  assign par = ^data;
endmodule // vpt_parity

// ---- vpt_props.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// translator port checker
// ------------------------------------------------------------
module vpt_props
  import vpt_pkg::*;
(
  input wire logic                               clk,
  input wire logic                               rst_b,
  input wire logic                               paging_on,
  input wire logic [vpt_pkg::VPT_PPAGE_BITS-1:0] user_pt_base,
  input wire logic [vpt_pkg::VPT_PPAGE_BITS-1:0] exec_pt_base,
  input wire logic                               ref_req,
  input wire logic [vpt_pkg::VPT_VADDR_BITS-1:0] ref_vaddr,
  input wire logic                               ref_write,
  input wire logic                               ref_intr,
  input wire logic                               ref_phys,
  input wire logic                               ref_ready,
  input wire logic                               ref_done,
  input wire logic [vpt_pkg::VPT_PADDR_BITS-1:0] ref_paddr,
  input wire logic                               ref_fast,
  input wire logic                               refill_req,
  input wire logic [vpt_pkg::VPT_VPAGE_BITS-1:0] refill_vpage,
  input wire logic                               refill_user,
  input wire logic                               refill_write,
  input wire logic [vpt_pkg::VPT_PADDR_BITS-1:0] sect_ptr_addr,
  input wire logic                               refill_ack,
  input wire logic [vpt_pkg::VPT_PPAGE_BITS-1:0] refill_ppn,
  input wire logic [1:0]                         refill_fail,
  input wire logic                               trap_req,
  input wire logic [1:0]                         trap_cause,
  input wire logic [vpt_pkg::VPT_PADDR_BITS-1:0] trap_fail_addr,
  input wire logic [vpt_pkg::VPT_PADDR_BITS-1:0] trap_pc_addr,
  input wire logic [vpt_pkg::VPT_PADDR_BITS-1:0] trap_new_addr,
  input wire logic                               trap_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic take;
  logic byp;
  // a take that skips the table: pager off, microcode reference or fast memory
  assign take = ref_req && ref_ready;
  assign byp  = !paging_on || ref_phys || (ref_vaddr < VPT_AC_LIMIT);
  property p_bypass;
    take && byp |=> ref_done && ref_paddr == {1'b0, $past(ref_vaddr)};
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass address wrong");
  property p_fast;
    take && paging_on && !ref_phys && ref_vaddr < VPT_AC_LIMIT |=> ref_fast;
  endproperty
  a_fast: assert property (p_fast) else $error("fast flag missing");
  property p_busy;
    take && !byp |=> !ref_ready ##1 (ref_done || refill_req);
  endproperty
  a_busy: assert property (p_busy) else $error("lookup timing wrong");
  property p_space;
    take && !byp && ref_intr |-> ##2 (!refill_req || !refill_user);
  endproperty
  a_space: assert property (p_space) else $error("interrupt fetch not executive");
  property p_wr;
    take && !byp |-> ##2 (!refill_req || refill_write == $past(ref_write, 2));
  endproperty
  a_wr: assert property (p_wr) else $error("refill write flag wrong");
  property p_hold;
    refill_req && !refill_ack |=> refill_req && $stable(refill_vpage);
  endproperty
  a_hold: assert property (p_hold) else $error("refill request dropped");
  property p_fill;
    refill_req && refill_ack && refill_fail == VPT_FAIL_NONE
      |=> ref_done && ref_paddr[18:9] == $past(refill_ppn);
  endproperty
  a_fill: assert property (p_fill) else $error("refill page not used");
  property p_trap;
    refill_req && refill_ack && refill_fail != VPT_FAIL_NONE
      |=> trap_req && !ref_done && trap_cause == $past(refill_fail);
  endproperty
  a_trap: assert property (p_trap) else $error("soft failure not trapped");
  property p_sect;
    refill_req |-> sect_ptr_addr == {refill_user ? user_pt_base : exec_pt_base,
      VPT_SECT_PTR_WORD};
  endproperty
  a_sect: assert property (p_sect) else $error("section pointer address wrong");
  property p_pfw;
    trap_req |-> trap_fail_addr == {user_pt_base, VPT_PF_WORD}
      && trap_pc_addr == {user_pt_base, VPT_PF_OLD_PC}
      && trap_new_addr == {user_pt_base, VPT_PF_NEW_PC};
  endproperty
  a_pfw: assert property (p_pfw) else $error("trap word address wrong");
endmodule // vpt_props
bind vpt_translator vpt_props u_props (.clk(clk), .rst_b(rst_b), .paging_on(paging_on),
  .user_pt_base(user_pt_base), .exec_pt_base(exec_pt_base), .ref_req(ref_req),
  .ref_vaddr(ref_vaddr), .ref_write(ref_write), .ref_intr(ref_intr), .ref_phys(ref_phys),
  .ref_ready(ref_ready), .ref_done(ref_done), .ref_paddr(ref_paddr), .ref_fast(ref_fast),
  .refill_req(refill_req), .refill_vpage(refill_vpage), .refill_user(refill_user),
  .refill_write(refill_write), .sect_ptr_addr(sect_ptr_addr), .refill_ack(refill_ack),
  .refill_ppn(refill_ppn), .refill_fail(refill_fail), .trap_req(trap_req),
  .trap_cause(trap_cause), .trap_fail_addr(trap_fail_addr), .trap_pc_addr(trap_pc_addr),
  .trap_new_addr(trap_new_addr), .trap_ack(trap_ack));

// ---- vpt_ucode_model.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// microcode refill and trap responder
// ------------------------------------------------------------
module vpt_ucode_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       refill_req,
  input  wire logic       refill_user,
  input  wire logic [8:0] refill_vpage,
  input  wire logic       trap_req,
  input  wire logic [1:0] cfg_fail,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_mod,
  input  wire logic [3:0] cfg_wait,
  output logic            refill_ack,
  output logic [9:0]      refill_ppn,
  output logic            refill_writable,
  output logic            refill_modified,
  output logic            refill_cache,
  output logic [1:0]      refill_fail,
  output logic            trap_ack
);
  logic [3:0] wait_reg;
  // stall counter; long waits keep the pager parked in refill
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg <= 4'h0;
      trap_ack <= 1'b0;
    end else begin
      wait_reg <= (refill_req && !refill_ack) ? wait_reg + 4'h1 : 4'h0;
      trap_ack <= trap_req && !trap_ack;
    end
  end
  // fields mean something only with the ack; otherwise they show the inverse
  assign refill_ack      = refill_req && (wait_reg == cfg_wait);
  assign refill_ppn      = {10{refill_ack}} ~^ {refill_user, refill_vpage};
  assign refill_writable = refill_ack ~^ cfg_wr;
  assign refill_modified = refill_ack ~^ cfg_mod;
  assign refill_cache    = refill_ack ~^ refill_vpage[1];
  assign refill_fail     = {2{refill_ack}} ~^ cfg_fail;
endmodule // vpt_ucode_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import vpt_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, paging_on = 1'b0, user_mode = 1'b0;
  logic [9:0]  user_pt_base = 10'h2A5, exec_pt_base = 10'h13C;
  logic        ref_req = 1'b0, ref_write = 1'b0, ref_intr = 1'b0, ref_phys = 1'b0;
  logic [17:0] ref_vaddr = 18'h00000;
  logic        inval_req = 1'b0;
  logic [8:0]  inval_vpage = 9'h000;
  logic [1:0]  cfg_fail = 2'h0;
  logic        cfg_wr = 1'b0, cfg_mod = 1'b0;
  logic [3:0]  cfg_wait = 4'h0;
  logic        ref_ready, ref_done, ref_cache, refill_req, refill_user, refill_ack, trap_req;
  logic        refill_write, refill_writable, refill_modified, refill_cache, trap_ack, perr;
  logic [18:0] ref_paddr;
  logic [8:0]  refill_vpage;
  logic [9:0]  refill_ppn;
  logic [1:0]  refill_fail;
  int          n_fail = 0, total_checks = 0;
  logic [31:0] rs = 32'd67795;
  logic        tv [512], ts [512], tm [512];
  always #12.5 clk = ~clk;
  vpt_translator u_dut (.clk(clk), .rst_b(rst_b), .paging_on(paging_on),
    .user_mode(user_mode), .user_pt_base(user_pt_base), .exec_pt_base(exec_pt_base),
    .ref_req(ref_req), .ref_vaddr(ref_vaddr), .ref_write(ref_write), .ref_intr(ref_intr),
    .ref_phys(ref_phys), .ref_ready(ref_ready), .ref_done(ref_done), .ref_paddr(ref_paddr),
    .ref_cache(ref_cache), .ref_fast(), .refill_req(refill_req), .refill_vpage(refill_vpage),
    .refill_user(refill_user), .refill_write(refill_write), .sect_ptr_addr(),
    .refill_ack(refill_ack), .refill_ppn(refill_ppn), .refill_writable(refill_writable),
    .refill_modified(refill_modified), .refill_cache(refill_cache), .refill_fail(refill_fail),
    .trap_req(trap_req), .trap_cause(), .trap_fail_addr(), .trap_pc_addr(), .trap_new_addr(),
    .trap_ack(trap_ack), .inval_req(inval_req), .inval_vpage(inval_vpage), .parity_err(perr));
  vpt_ucode_model u_ucode (.clk(clk), .rst_b(rst_b), .refill_req(refill_req),
    .refill_user(refill_user), .refill_vpage(refill_vpage), .trap_req(trap_req),
    .cfg_fail(cfg_fail), .cfg_wr(cfg_wr), .cfg_mod(cfg_mod), .cfg_wait(cfg_wait),
    .refill_ack(refill_ack), .refill_ppn(refill_ppn), .refill_writable(refill_writable),
    .refill_modified(refill_modified), .refill_cache(refill_cache),
    .refill_fail(refill_fail), .trap_ack(trap_ack));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // a miss is due on invalid, other space, or write without modified
  function automatic logic exp_miss(input logic [8:0] vp, input logic sp, input logic wr);
    return !tv[vp] || ts[vp] != sp || (wr && !tm[vp]);
  endfunction
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one reference; records whether a refill or a trap showed up on the way
  task automatic acc(input logic [17:0] va, input logic wr, input logic intr,
                     input logic ph, output logic sr, output logic st);
    int i;
    sr = 1'b0;
    st = 1'b0;
    @(posedge clk);
    ref_req <= 1'b1;
    ref_vaddr <= va;
    ref_write <= wr;
    ref_intr <= intr;
    ref_phys <= ph;
    @(posedge clk);
    ref_req <= 1'b0;
    for (i = 0; i < 100; i++) begin
      #1;
      sr |= (refill_req === 1'b1);
      st |= (trap_req === 1'b1);
      if (ref_done === 1'b1 || (st && ref_ready === 1'b1)) break;
      @(posedge clk);
    end
    if (i == 100) begin
      n_fail++;
      $display("[FAIL] completion expected 1 seen 0");
      test_done();
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic sr, st, sp, wr, intr, ph, mi, byp, cw, cm;
    logic [1:0]  fl;
    logic [17:0] va;
    logic [31:0] r;
    int k;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // table memory has no reset, so every location is cleared first
    for (k = 0; k < 512; k++) begin
      @(posedge clk);
      inval_req <= 1'b1;
      inval_vpage <= k[8:0];
      tv[k] = 1'b0;
    end
    @(posedge clk);
    inval_req <= 1'b0;
    for (k = 0; k < 20; k++) begin
      r = xs();
      acc(r[17:0], r[18], 1'b0, 1'b0, sr, st);
      chk("paddr_off", {1'b0, r[17:0]}, ref_paddr);
    end
    // few pages and the top page, so hits, space clashes and M upgrades recur
    for (k = 0; k < 300; k++) begin
      r = xs();
      va = {(r[3] ? 9'h1FF : {6'h00, r[2:0]}), r[12:4]};
      wr = r[13];
      intr = r[14] & r[15];
      ph = r[16] & r[17] & r[18];
      sp = intr ? 1'b0 : r[19];
      cw = r[24];
      cm = r[25];
      fl = (wr && !cw) ? VPT_FAIL_WPROT : ((r[20] & r[21]) ? r[23:22] : VPT_FAIL_NONE);
      byp = ph || va < 18'd16;
      @(posedge clk);
      paging_on <= 1'b1;
      user_mode <= r[19];
      cfg_fail <= fl;
      cfg_wr <= cw;
      cfg_mod <= cm;
      cfg_wait <= r[29:26];
      if (r[31:28] == 4'h0) begin
        @(posedge clk);
        inval_req <= 1'b1;
        inval_vpage <= va[17:9];
        @(posedge clk);
        inval_req <= 1'b0;
        tv[va[17:9]] = 1'b0;
      end
      mi = !byp && exp_miss(va[17:9], sp, wr);
      acc(va, wr, intr, ph, sr, st);
      chk("refill_seen", 19'(mi), 19'(sr));
      chk("trap_seen", 19'(mi && fl != VPT_FAIL_NONE), 19'(st));
      chk("parity_err", 19'h00000, 19'(perr));
      if (!(mi && fl != VPT_FAIL_NONE)) begin
        // the responder hands back {space, vpage} as the physical page
        chk("paddr", byp ? {1'b0, va} : {sp, va}, ref_paddr);
        if (!byp) chk("cache", 19'(va[10]), 19'(ref_cache));
      end
      if (mi && fl != VPT_FAIL_INACC && fl != VPT_FAIL_WPROT) begin
        tv[va[17:9]] = 1'b1;
        ts[va[17:9]] = sp;
        tm[va[17:9]] = cm | (wr & cw);
      end
    end
    test_done();
  end
endmodule // tb_top
